//--- core/timed_out_pkg.sv
// constants, register map and shared types of the triggered real-time output port
// Summary of operation
// - pin-mode register: one bit per output
// - reset clears pin-mode register to zero
// - reset clears control register to zero
// - control bit 7 enables the unit
// - control bit 6 picks trigger pin edge
// - control bit 5 picks one or two channels
// - control bit 4 uses the trigger pin
// - two channels: nibble triggers per trigger select
// - one channel: all bits on one trigger
// - enabled unit copies buffer on its trigger
// - real-time bits drive latch, port bits zero
// - disabled unit drives all outputs zero
// - port writes skip real-time bits
// - buffer write width follows channel mode
// - buffer reads return both nibbles masked
package timed_out_pkg;
    localparam int ADDR_W = 12;
    // these offsets are word indices; byte address is four times the index
    localparam logic [31:0] PIN_MODE_INDEX = 32'hfffff3a4;
    localparam logic [31:0] UNIT_CTRL_INDEX = 32'hfffff3a6;
    localparam logic [ADDR_W-1:0] PIN_MODE_ADDR = {PIN_MODE_INDEX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] UNIT_CTRL_ADDR = {UNIT_CTRL_INDEX[ADDR_W-3:0], 2'b00};
    localparam logic [ADDR_W-1:0] LOW_BUF_ADDR = 12'h010;
    localparam logic [ADDR_W-1:0] HIGH_BUF_ADDR = 12'h014;
    localparam logic [ADDR_W-1:0] PORT_LATCH_ADDR = 12'h018;
    localparam logic [ADDR_W-1:0] OUT_STATE_ADDR = 12'h01c;
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_EDGE_BIT = 6;
    localparam int CTRL_BYTE_BIT = 5;
    localparam int CTRL_EXT_BIT = 4;
    localparam logic [7:0] CTRL_WMASK = 8'hf0;
    localparam logic [7:0] PIN_MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [7:0] LOW_NIBBLE = 8'h0f;
    localparam logic [7:0] HIGH_NIBBLE = 8'hf0;
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_MODE,
        SEL_CTRL,
        SEL_LOW_BUF,
        SEL_HIGH_BUF,
        SEL_LATCH,
        SEL_STATE
    } reg_sel_t;
endpackage : timed_out_pkg

//--- core/ext_trigger_detect.sv
// trigger pin synchroniser and selected-edge pulse
`timescale 1ns/1ns
module ext_trigger_detect
    import timed_out_pkg::*;
(
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ext_trigger_pin, // asynchronous trigger pin
    input wire logic rising_sel, // 1 rising, 0 falling
    input wire logic use_en, // pin used as trigger
    output logic trig_pulse // one-cycle pulse on selected edge
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic pulse;
    } det_t;
    det_t s_r;
    det_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = ext_trigger_pin;
        s_nxt.sync = s_r.meta;
        s_nxt.prev = s_r.sync;
        // only the second and third stages feed the edge compare
        s_nxt.pulse = use_en && (rising_sel ? (s_r.sync && !s_r.prev) : (!s_r.sync && s_r.prev));
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign trig_pulse = s_r.pulse;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_edge_pulse_one: assert property (trig_pulse |=> !trig_pulse)
        else $error("trigger pulse longer than one cycle");
    chk_edge_needs_use: assert property ($rose(trig_pulse) |-> $past(use_en))
        else $error("trigger pulse while pin not used");
endmodule : ext_trigger_detect

//--- core/trigger_route.sv
// routes timer and pin triggers to the two nibble loads
`timescale 1ns/1ns
module trigger_route
    import timed_out_pkg::*;
(
    input wire logic unit_enable, // unit enable
    input wire logic byte_mode, // one 8-bit channel
    input wire logic ext_trigger_use, // pin trigger used
    input wire logic timer_a_irq, // first timer pulse
    input wire logic timer_b_irq, // second timer pulse
    input wire logic ext_pulse, // detected pin edge
    output logic load_hi, // copy high nibble
    output logic load_lo // copy low nibble
);
    logic byte_trig;

    always_comb begin
        byte_trig = ext_trigger_use ? ext_pulse : timer_a_irq;
        if (!unit_enable) begin
            load_hi = 1'b0;
            load_lo = 1'b0;
        end else if (byte_mode) begin
            load_hi = byte_trig;
            load_lo = byte_trig;
        end else begin
            load_hi = ext_trigger_use ? timer_a_irq : timer_b_irq;
            load_lo = ext_trigger_use ? ext_pulse : timer_a_irq;
        end
    end
endmodule : trigger_route

//--- core/timed_output_unit.sv
// triggered real-time output port with AXI4-Lite register slave
`timescale 1ns/1ns
module timed_output_unit
    import timed_out_pkg::*;
(
    input wire logic aclk, // 100 MHz clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic timer_a_irq, // first timer interrupt pulse
    input wire logic timer_b_irq, // second timer interrupt pulse
    input wire logic ext_trigger_pin, // external trigger pin
    output logic [7:0] timed_output_pins // real-time outputs
);
    typedef struct packed {
        logic aw_full;
        logic [ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] pin_mode;
        logic [7:0] ctrl;
        logic [7:0] bufv;
        logic [7:0] latch;
        logic [7:0] pins;
    } unit_t;

    localparam unit_t UNIT_RST = '{
        aw_full: 1'b0,
        aw_addr: '0,
        w_full: 1'b0,
        w_data: 8'h00,
        w_lane0: 1'b0,
        awready: 1'b0,
        wready: 1'b0,
        bvalid: 1'b0,
        bresp: RESP_OKAY,
        arready: 1'b0,
        rvalid: 1'b0,
        rdata: 32'h0000_0000,
        rresp: RESP_OKAY,
        pin_mode: PIN_MODE_RST,
        ctrl: CTRL_RST,
        bufv: BUF_RST,
        latch: LATCH_RST,
        pins: 8'h00
    };

    unit_t s_r;
    unit_t s_nxt;
    logic ext_pulse;
    logic load_hi;
    logic load_lo;
    logic wr_go;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [7:0] load_mask;

    // shared by the read and the write path
    function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
        unique case (addr)
            PIN_MODE_ADDR: decode = SEL_MODE;
            UNIT_CTRL_ADDR: decode = SEL_CTRL;
            LOW_BUF_ADDR: decode = SEL_LOW_BUF;
            HIGH_BUF_ADDR: decode = SEL_HIGH_BUF;
            PORT_LATCH_ADDR: decode = SEL_LATCH;
            OUT_STATE_ADDR: decode = SEL_STATE;
            default: decode = SEL_NONE;
        endcase
    endfunction : decode

    function automatic logic [7:0] read_byte(input reg_sel_t sel, input unit_t st);
        unique case (sel)
            SEL_MODE: read_byte = st.pin_mode;
            SEL_CTRL: read_byte = st.ctrl & CTRL_WMASK;
            SEL_LOW_BUF, SEL_HIGH_BUF: read_byte = st.bufv & st.pin_mode;
            SEL_LATCH: read_byte = st.latch;
            SEL_STATE: read_byte = st.pins;
            SEL_NONE: read_byte = 8'h00;
        endcase
    endfunction : read_byte

    ext_trigger_detect u_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_trigger_pin(ext_trigger_pin),
        .rising_sel(s_r.ctrl[CTRL_EDGE_BIT]),
        .use_en(s_r.ctrl[CTRL_EXT_BIT]),
        .trig_pulse(ext_pulse)
    );

    trigger_route u_route (
        .unit_enable(s_r.ctrl[CTRL_EN_BIT]),
        .byte_mode(s_r.ctrl[CTRL_BYTE_BIT]),
        .ext_trigger_use(s_r.ctrl[CTRL_EXT_BIT]),
        .timer_a_irq(timer_a_irq),
        .timer_b_irq(timer_b_irq),
        .ext_pulse(ext_pulse),
        .load_hi(load_hi),
        .load_lo(load_lo)
    );

    always_comb begin
        s_nxt = s_r;
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_awvalid && s_r.awready) begin
            s_nxt.aw_full = 1'b1;
            s_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wready) begin
            s_nxt.w_full = 1'b1;
            s_nxt.w_data = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        // write completes once both halves are held and no response is pending
        wr_go = s_nxt.aw_full && s_nxt.w_full && !s_nxt.bvalid;
        wr_sel = decode(s_nxt.aw_addr);
        rd_sel = decode(s_axi_araddr);
        if (wr_go) begin
            s_nxt.aw_full = 1'b0;
            s_nxt.w_full = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        if (s_axi_arvalid && s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            s_nxt.rdata = {24'h00_0000, read_byte(rd_sel, s_r)};
        end
        // only lane 0 carries the 8-bit registers; other lanes are ignored
        if (wr_go && s_nxt.w_lane0) begin
            unique case (wr_sel)
                SEL_MODE: s_nxt.pin_mode = s_nxt.w_data;
                SEL_CTRL: s_nxt.ctrl = s_nxt.w_data & CTRL_WMASK;
                SEL_LOW_BUF: begin
                    if (s_r.ctrl[CTRL_BYTE_BIT]) begin
                        s_nxt.bufv = s_nxt.w_data;
                    end else begin
                        s_nxt.bufv = (s_r.bufv & HIGH_NIBBLE) | (s_nxt.w_data & LOW_NIBBLE);
                    end
                end
                SEL_HIGH_BUF: begin
                    if (s_r.ctrl[CTRL_BYTE_BIT]) begin
                        s_nxt.bufv = s_nxt.w_data;
                    end else begin
                        s_nxt.bufv = (s_r.bufv & LOW_NIBBLE) | (s_nxt.w_data & HIGH_NIBBLE);
                    end
                end
                SEL_LATCH: s_nxt.latch = (s_r.latch & s_r.pin_mode) | (s_nxt.w_data & ~s_r.pin_mode);
                SEL_STATE, SEL_NONE: s_nxt.latch = s_nxt.latch;
            endcase
        end
        // the transfer uses the buffer as it stood before this cycle's write;
        // port-mode bits keep their port value so a later switch starts clean
        load_mask = ({{4{load_hi}}, {4{load_lo}}}) & s_r.pin_mode;
        s_nxt.latch = (s_nxt.latch & ~load_mask) | (s_r.bufv & load_mask);
        s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_full && !s_nxt.bvalid;
        s_nxt.arready = !s_nxt.rvalid;
        if (s_nxt.ctrl[CTRL_EN_BIT]) begin
            s_nxt.pins = s_nxt.latch & s_nxt.pin_mode;
        end else begin
            s_nxt.pins = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= UNIT_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign timed_output_pins = s_r.pins;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        wr_go && s_nxt.w_lane0;
    endsequence

    sequence s_write_answered;
        ##1 s_axi_bvalid;
    endsequence

    chk_write_answer: assert property (wr_go |-> s_write_answered)
        else $error("write response not one cycle after completion");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_mode_after_reset: assert property ($past(!aresetn) |-> s_r.pin_mode == 8'h00)
        else $error("pin mode not cleared by reset");
    chk_ctrl_after_reset: assert property ($past(!aresetn) |-> s_r.ctrl == 8'h00)
        else $error("control not cleared by reset");
    chk_pins_disabled: assert property (!s_r.ctrl[CTRL_EN_BIT] |-> timed_output_pins == 8'h00)
        else $error("outputs active while unit disabled");
    chk_pins_masked: assert property (s_r.ctrl[CTRL_EN_BIT] |-> (timed_output_pins & ~s_r.pin_mode) == 8'h00)
        else $error("port-mode bit driven high");
    chk_pins_follow: assert property (s_r.ctrl[CTRL_EN_BIT] |-> timed_output_pins == (s_r.latch & s_r.pin_mode))
        else $error("output does not show latched value");
    chk_low_transfer: assert property (load_lo |=> (s_r.latch & $past(s_r.pin_mode) & LOW_NIBBLE)
        == ($past(s_r.bufv) & $past(s_r.pin_mode) & LOW_NIBBLE))
        else $error("low nibble not transferred");
    chk_high_transfer: assert property (load_hi |=> (s_r.latch & $past(s_r.pin_mode) & HIGH_NIBBLE)
        == ($past(s_r.bufv) & $past(s_r.pin_mode) & HIGH_NIBBLE))
        else $error("high nibble not transferred");
    chk_split_triggers: assert property (s_r.ctrl[CTRL_EN_BIT] && !s_r.ctrl[CTRL_BYTE_BIT]
        && !s_r.ctrl[CTRL_EXT_BIT] |-> load_hi == timer_b_irq && load_lo == timer_a_irq)
        else $error("two-channel trigger routing wrong");
    chk_byte_triggers: assert property (s_r.ctrl[CTRL_EN_BIT] && s_r.ctrl[CTRL_BYTE_BIT]
        |-> load_hi == load_lo)
        else $error("one-channel nibbles loaded apart");
    chk_port_write_skip: assert property (s_write_taken ##0 (wr_sel == SEL_LATCH) ##0 !load_hi ##0 !load_lo
        |=> (s_r.latch & $past(s_r.pin_mode)) == ($past(s_r.latch) & $past(s_r.pin_mode)))
        else $error("port write changed a real-time bit");
    chk_byte_buf_write: assert property (s_write_taken ##0 s_r.ctrl[CTRL_BYTE_BIT]
        ##0 (wr_sel == SEL_LOW_BUF || wr_sel == SEL_HIGH_BUF) |=> s_r.bufv == $past(s_nxt.w_data))
        else $error("one-channel buffer write not full width");
    chk_split_low_write: assert property (s_write_taken ##0 !s_r.ctrl[CTRL_BYTE_BIT] ##0 (wr_sel == SEL_LOW_BUF)
        |=> (s_r.bufv & HIGH_NIBBLE) == ($past(s_r.bufv) & HIGH_NIBBLE))
        else $error("low buffer write touched high nibble");
    chk_buf_read_mask: assert property (s_axi_arvalid && s_axi_arready && rd_sel == SEL_LOW_BUF
        |=> s_axi_rdata == {24'h00_0000, $past(s_r.bufv & s_r.pin_mode)})
        else $error("buffer read not masked by pin mode");
    chk_ctrl_low_zero: assert property (s_r.ctrl[3:0] == 4'h0)
        else $error("control low bits not zero");

    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // routing checks for the modes not covered above
    chk_split_ext_route: assert property (s_r.ctrl[CTRL_EN_BIT] && !s_r.ctrl[CTRL_BYTE_BIT]
        && s_r.ctrl[CTRL_EXT_BIT] |-> load_hi == timer_a_irq && load_lo == ext_pulse)
        else $error("two-channel pin routing wrong");
    chk_byte_timer_route: assert property (s_r.ctrl[CTRL_EN_BIT] && s_r.ctrl[CTRL_BYTE_BIT]
        && !s_r.ctrl[CTRL_EXT_BIT] |-> load_lo == timer_a_irq)
        else $error("one-channel timer routing wrong");
    chk_byte_pin_route: assert property (s_r.ctrl[CTRL_EN_BIT] && s_r.ctrl[CTRL_BYTE_BIT]
        && s_r.ctrl[CTRL_EXT_BIT] |-> load_lo == ext_pulse)
        else $error("one-channel pin routing wrong");
    chk_no_load_off: assert property (!s_r.ctrl[CTRL_EN_BIT]
        |-> !load_hi && !load_lo)
        else $error("transfer while unit disabled");
    chk_pin_unused_quiet: assert property (!$past(s_r.ctrl[CTRL_EXT_BIT])
        |-> !ext_pulse)
        else $error("pin pulse while pin unused");

    // register writes
    chk_ctrl_write: assert property (s_write_taken ##0 (wr_sel == SEL_CTRL)
        |=> s_r.ctrl == ($past(s_nxt.w_data) & CTRL_WMASK))
        else $error("control write lost");
    chk_mode_write: assert property (s_write_taken ##0 (wr_sel == SEL_MODE)
        |=> s_r.pin_mode == $past(s_nxt.w_data))
        else $error("pin mode write lost");
    chk_split_high_write: assert property (s_write_taken ##0 !s_r.ctrl[CTRL_BYTE_BIT] ##0 (wr_sel == SEL_HIGH_BUF)
        |=> (s_r.bufv & LOW_NIBBLE) == ($past(s_r.bufv) & LOW_NIBBLE))
        else $error("high buffer write touched low nibble");
    chk_lane_ignored: assert property (wr_go && !s_nxt.w_lane0
        |=> s_r.pin_mode == $past(s_r.pin_mode) && s_r.ctrl == $past(s_r.ctrl))
        else $error("write without lane 0 took effect");
    chk_buf_quiet: assert property (!(wr_go && s_nxt.w_lane0 && (wr_sel == SEL_LOW_BUF || wr_sel == SEL_HIGH_BUF))
        |=> s_r.bufv == $past(s_r.bufv))
        else $error("buffer changed without a write");
    chk_latch_quiet: assert property (!(wr_go && s_nxt.w_lane0 && wr_sel == SEL_LATCH) && !load_hi && !load_lo
        |=> s_r.latch == $past(s_r.latch))
        else $error("latch changed without cause");
    chk_unmapped_write: assert property (wr_go && wr_sel == SEL_NONE
        |=> s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");

    // register reads
    chk_high_read_mask: assert property (s_read_taken ##0 (rd_sel == SEL_HIGH_BUF)
        |=> s_axi_rdata == {24'h00_0000, $past(s_r.bufv & s_r.pin_mode)})
        else $error("high buffer read not masked");
    chk_ctrl_read_low: assert property (s_read_taken ##0 (rd_sel == SEL_CTRL)
        |=> s_axi_rdata[3:0] == 4'h0)
        else $error("control low bits read nonzero");
    chk_unmapped_read: assert property (s_read_taken ##0 (rd_sel == SEL_NONE)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_state_read: assert property (s_read_taken ##0 (rd_sel == SEL_STATE)
        |=> s_axi_rdata == {24'h00_0000, $past(timed_output_pins)})
        else $error("output state read wrong");

    // handshake holding, busy flags and state after reset
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_write_busy: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_read_busy: assert property (s_axi_rvalid
        |-> !s_axi_arready)
        else $error("read taken while data pending");
    chk_bus_after_reset: assert property ($past(!aresetn)
        |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("bus response after reset");
    chk_pins_after_reset: assert property ($past(!aresetn)
        |-> timed_output_pins == 8'h00)
        else $error("outputs not cleared by reset");
endmodule : timed_output_unit

//--- testbench/step_load_model.sv
// behavioural stepper load: drives the trigger pin and counts output steps
`timescale 1ns/1ns
module step_load_model (
    input wire logic aclk, // system clock
    input wire logic trig_level, // trigger level asked for by the bench
    input wire logic [7:0] timed_output_pins, // pattern from the port
    output logic ext_trigger_pin, // trigger pin toward the port
    output logic [7:0] step_count // output changes seen
);
    logic [7:0] last_pins;
    initial begin
        ext_trigger_pin = 1'b0;
        step_count = 8'h00;
        last_pins = 8'h00;
    end
    // pin moves just after an edge, so the port sees it as an unrelated async input
    always @(posedge aclk) begin
        ext_trigger_pin <= trig_level;
        last_pins <= timed_output_pins;
        if (timed_output_pins !== last_pins) step_count <= step_count + 8'h01;
    end
endmodule : step_load_model

//--- testbench/tb_top.sv
// register and trigger tests of the triggered real-time output port
`timescale 1ns/1ns
module tb_top
    import timed_out_pkg::*;
    ;
    logic aclk, aresetn;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic timer_a_irq, timer_b_irq, ext_trigger_pin, trig_level;
    logic [7:0] timed_output_pins, exp_latch, v, step_count;
    logic [7:0] cfg [6] = '{8'h80, 8'h90, 8'ha0, 8'hb0, 8'hd0, 8'hf0};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;

    timed_output_unit uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .timer_a_irq(timer_a_irq), .timer_b_irq(timer_b_irq),
        .ext_trigger_pin(ext_trigger_pin), .timed_output_pins(timed_output_pins));
    step_load_model load (.aclk(aclk), .trig_level(trig_level), .timed_output_pins(timed_output_pins),
        .ext_trigger_pin(ext_trigger_pin), .step_count(step_count));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_sim

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // address and data offered together, bready held until the response is sampled
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid === 1'b1));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rchk(input string name, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid === 1'b1));
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        check(name, rd, exp);
    endtask : rchk

    // src 0 timer a, 1 timer b, 2 pin rise, 3 pin fall; buffers reloaded well before each trigger
    task automatic fire(input int src, input logic [7:0] ctrl);
        logic hi, lo, pin_ev;
        v = v + 8'h37;
        wr(LOW_BUF_ADDR, v);
        wr(HIGH_BUF_ADDR, v);
        @(posedge aclk);
        if (src == 0) timer_a_irq <= 1'b1;
        if (src == 1) timer_b_irq <= 1'b1;
        if (src == 2) trig_level <= 1'b1;
        if (src == 3) trig_level <= 1'b0;
        @(posedge aclk);
        timer_a_irq <= 1'b0;
        timer_b_irq <= 1'b0;
        repeat (9) @(posedge aclk);
        pin_ev = ctrl[CTRL_EXT_BIT] && ((src == 2 && ctrl[CTRL_EDGE_BIT]) || (src == 3 && !ctrl[CTRL_EDGE_BIT]));
        lo = ctrl[CTRL_EXT_BIT] ? pin_ev : (src == 0);
        hi = ctrl[CTRL_BYTE_BIT] ? lo : (ctrl[CTRL_EXT_BIT] ? (src == 0) : (src == 1));
        if (lo) exp_latch[3:0] = v[3:0];
        if (hi) exp_latch[7:4] = v[7:4];
        @(negedge aclk);
        check("pins after trigger", timed_output_pins, exp_latch);
    endtask : fire

    initial begin
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        {timer_a_irq, timer_b_irq, trig_level} = '0;
        v = 8'h00;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("mode reset", PIN_MODE_ADDR, 32'h00);
        rchk("ctrl reset", UNIT_CTRL_ADDR, 32'h00);
        rchk("unmapped read", 12'h100, 32'h00);
        check("unmapped rresp", resp, RESP_SLVERR);
        wr(12'h100, 8'hff);
        check("unmapped bresp", resp, RESP_SLVERR);
        wr(UNIT_CTRL_ADDR, 8'h5f);
        rchk("ctrl low bits", UNIT_CTRL_ADDR, 32'h50);
        // initial value goes in while the bits are still port mode
        wr(PORT_LATCH_ADDR, 8'h5a);
        wr(PIN_MODE_ADDR, 8'hf0);
        rchk("mode rw", PIN_MODE_ADDR, 32'hf0);
        s_axi_wstrb <= 4'he;
        wr(PIN_MODE_ADDR, 8'h00);
        s_axi_wstrb <= 4'hf;
        rchk("lane0 off", PIN_MODE_ADDR, 32'hf0);
        wr(PORT_LATCH_ADDR, 8'h00);
        rchk("latch guard", PORT_LATCH_ADDR, 32'h50);
        exp_latch = 8'h50;
        @(negedge aclk);
        check("pins disabled", timed_output_pins, 32'h00);
        wr(UNIT_CTRL_ADDR, 8'h00);
        wr(PIN_MODE_ADDR, 8'hff);
        wr(LOW_BUF_ADDR, 8'ha5);
        wr(HIGH_BUF_ADDR, 8'h3c);
        rchk("buf two channel", HIGH_BUF_ADDR, 32'h35);
        wr(PIN_MODE_ADDR, 8'h0f);
        rchk("buf masked", LOW_BUF_ADDR, 32'h05);
        wr(UNIT_CTRL_ADDR, 8'h20);
        wr(HIGH_BUF_ADDR, 8'h96);
        wr(PIN_MODE_ADDR, 8'hff);
        rchk("buf one channel", LOW_BUF_ADDR, 32'h96);
        foreach (cfg[i]) begin
            wr(UNIT_CTRL_ADDR, cfg[i]);
            repeat (2) @(negedge aclk);
            check("pins enabled", timed_output_pins, exp_latch);
            for (int s = 0; s < 4; s++) begin
                fire(s, cfg[i]);
            end
        end
        wr(PIN_MODE_ADDR, 8'h0f);
        repeat (2) @(negedge aclk);
        check("pins port bits", timed_output_pins, exp_latch & 8'h0f);
        rchk("output state", OUT_STATE_ADDR, {24'h000000, exp_latch & 8'h0f});
        wr(UNIT_CTRL_ADDR, 8'h00);
        repeat (2) @(negedge aclk);
        check("pins off again", timed_output_pins, 32'h00);
        check("load steps", step_count == 8'h00, 1'b0);
        end_sim();
    end
endmodule : tb_top
